// [rtl/syscall_pkg.sv]
/*
  constants for the flash system call handler: opcodes, keys, status codes,
  field positions and protection modes.
  assumes a single 100 MHz clock domain and a register port of two words.
*/
package syscall_pkg;
  localparam logic [7:0]  FIRST_KEY        = 8'hb6;
  localparam logic [7:0]  SECOND_KEY_BASE  = 8'hd3;
  localparam int          REQ_BIT          = 31;
  localparam int          PRIV_BIT         = 30;
  localparam logic [7:0]  OP_IDENT         = 8'h00;
  localparam logic [7:0]  OP_CONFIG_CLOCK  = 8'h15;
  localparam logic [7:0]  OP_LOAD_BYTES    = 8'h04;
  localparam logic [7:0]  OP_WRITE_ROW     = 8'h05;
  localparam logic [7:0]  OP_PROGRAM_ROW   = 8'h06;
  localparam logic [7:0]  OP_ERASE_ALL     = 8'h0a;
  localparam logic [7:0]  OP_CHECKSUM      = 8'h0b;
  localparam logic [7:0]  OP_WRITE_PROTECT = 8'h0d;
  localparam logic [7:0]  OP_NB_WRITE_ROW  = 8'h07;
  localparam logic [7:0]  OP_NB_PROG_ROW   = 8'h08;
  localparam logic [7:0]  OP_RESUME_NB     = 8'h09;
  localparam logic [3:0]  STATUS_OK        = 4'ha;
  localparam logic [31:0] STATUS_FAIL_BASE = 32'hf0000000;
  localparam logic [7:0]  ERR_BAD_KEY      = 8'h03;
  localparam logic [7:0]  ERR_NO_ACCESS    = 8'h01;
  localparam logic [7:0]  ERR_BAD_OPCODE   = 8'h02;
  localparam logic [7:0]  ERR_PUMP_CLOCK   = 8'h12;
  localparam logic [7:0]  ERR_NO_PENDING   = 8'h13;
  localparam logic [1:0]  MODE_OPEN        = 2'h0;
  localparam logic [1:0]  MODE_PROTECTED   = 2'h1;
  localparam logic [1:0]  MODE_KILL        = 2'h2;
  localparam int          FLASH_OP_NS      = 200;
  localparam int          CLK_NS           = 10;
  localparam int          FLASH_OP_CYCLES  = (FLASH_OP_NS + CLK_NS - 1) / CLK_NS;
  localparam int          ROW_BYTES        = 128;
  localparam int          IMO_48MHZ_CODE   = 48;
  typedef enum logic [1:0] {IDLE, CHECK, RUN, DONE} call_state_t;
endpackage : syscall_pkg

// [rtl/flash_system_call_handler.sv]
/*
  register-driven system call interpreter: argument and request words,
  key and access checks, identification, clock setup and flash call status.
  assumes the flash engine itself lies outside; flash_go pulses start it
  and flash_done reports its end. caller_is_debug marks the bus master.
*/
`timescale 1ns/1ps
// Operation
// [R1] identification returns family, silicon, revision, protection
// [R2] caller puts keys and opcode zero
// [R3] argument word gets silicon id, revision, 0xa
// [R4] request word gets family id and protection
// [R5] clock call selects oscillator at 48 MHz
// [R6] bad pump clock blocks flash, reports status; code checks it only once the oscillator is selected, never for resume
// [R7] identification refused only from debug in kill
// [R8] load bytes: debug open, or processor
// [R9] write row: debug open, or processor
// [R10] program row: debug open, or processor
// [R11] erase all: debug open only
// [R12] checksum: debug open/protected, or processor
// [R13] write protection: debug open/protected only
// [R14] non-blocking calls from processor only
// [R15] resume only from processor
// [R16] caller sets request bit to start
// [R17] keys checked, mismatch returns error
// [R18] completion clears privileged and request bits
// [R19] failure leaves 0xf00000yy in argument
// [R20] forbidden call fails without touching flash
// [R21] unused return bits are don't care
module flash_system_call_handler
  import syscall_pkg::*;
#(
  parameter logic [11:0] FAMILY_ID  = 12'h0a5,   // arbitrary value
  parameter logic [15:0] SILICON_ID = 16'h1234,  // arbitrary value
  parameter logic [7:0]  REVISION   = 8'h11      // arbitrary value
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        arg_wr,
  input  wire logic        req_wr,
  input  wire logic [31:0] wr_data,
  input  wire logic        caller_is_debug,
  input  wire logic [1:0]  protect_mode,
  input  wire logic [7:0]  pump_freq_mhz,
  input  wire logic        flash_done,
  output logic [31:0]      call_argument_word,
  output logic [31:0]      call_request_word,
  output logic             pump_from_osc,
  output logic             flash_go,
  output logic [7:0]       flash_op
);
  call_state_t state, next_state;
  logic [31:0] next_arg, next_req;
  logic        next_pump, next_go, next_pending, pending, caller;
  logic [7:0]  next_op;
  logic        next_caller;
  logic [7:0]  opcode;
  logic        allowed, known, flash_call;

  // elaboration-time guard on the flash step length
  if (FLASH_OP_CYCLES < 1) begin : g_bad_step
    $error("flash step too short");
  end

  assign opcode = call_request_word[7:0];

  // access table per caller and mode
  always_comb begin
    known      = 1'b1;
    allowed    = 1'b0;
    flash_call = 1'b0;
    case (opcode)
      OP_IDENT:         allowed = !caller || protect_mode != MODE_KILL;                               // [R7]
      OP_CONFIG_CLOCK:  allowed = !caller || protect_mode == MODE_OPEN;                               // [R5]
      OP_LOAD_BYTES:    allowed = !caller || protect_mode == MODE_OPEN;                               // [R8]
      OP_WRITE_ROW: begin
        allowed    = !caller || protect_mode == MODE_OPEN;                                            // [R9]
        flash_call = 1'b1;
      end
      OP_PROGRAM_ROW: begin
        allowed    = !caller || protect_mode == MODE_OPEN;                                            // [R10]
        flash_call = 1'b1;
      end
      OP_ERASE_ALL: begin
        allowed    = caller && protect_mode == MODE_OPEN;                                             // [R11]
        flash_call = 1'b1;
      end
      OP_CHECKSUM:      allowed = !caller || protect_mode != MODE_KILL;                               // [R12]
      OP_WRITE_PROTECT: begin
        allowed    = caller && protect_mode != MODE_KILL;                                             // [R13]
        flash_call = 1'b1;
      end
      OP_NB_WRITE_ROW, OP_NB_PROG_ROW: begin
        allowed    = !caller;                                                                          // [R14]
        flash_call = 1'b1;
      end
      OP_RESUME_NB:     allowed = !caller;                                                             // [R15]
      default: known = 1'b0;
    endcase
  end

  always_comb begin
    next_state   = state;
    next_arg     = call_argument_word;
    next_req     = call_request_word;
    next_pump    = pump_from_osc;
    next_go      = 1'b0;
    next_op      = flash_op;
    next_pending = pending;
    next_caller  = caller;
    case (state)
      IDLE: begin
        if (arg_wr) next_arg = wr_data;
        if (req_wr) begin
          next_req = {wr_data[REQ_BIT], 1'b0, wr_data[29:0]}; // privileged bit is not writable
          next_caller = caller_is_debug;
          if (wr_data[REQ_BIT]) next_state = CHECK;                                                    // [R16]
        end
      end
      CHECK: begin
        next_req[PRIV_BIT] = 1'b1;
        next_state = DONE;
        if (call_argument_word[7:0] != FIRST_KEY ||
            call_argument_word[15:8] != SECOND_KEY_BASE + opcode)                                     // [R17]
          next_arg = STATUS_FAIL_BASE | {24'h000000, ERR_BAD_KEY};                                     // [R19]
        else if (!known)
          next_arg = STATUS_FAIL_BASE | {24'h000000, ERR_BAD_OPCODE};
        else if (!allowed)
          next_arg = STATUS_FAIL_BASE | {24'h000000, ERR_NO_ACCESS};                                   // [R20]
        else if (flash_call && pump_from_osc && pump_freq_mhz != 8'(IMO_48MHZ_CODE))
          next_arg = STATUS_FAIL_BASE | {24'h000000, ERR_PUMP_CLOCK};                                  // [R6]
        else if (opcode == OP_RESUME_NB && !pending)
          next_arg = STATUS_FAIL_BASE | {24'h000000, ERR_NO_PENDING};
        else if (opcode == OP_IDENT) begin
          // bits 27:24 of the argument word and 15:14 of the request word left zero; callers ignore them [R21]
          next_arg = {STATUS_OK, 4'h0, REVISION, SILICON_ID};                                          // [R3]
          // lower half only, so the privileged bit set above survives
          next_req[15:0] = {2'b00, protect_mode, FAMILY_ID};                                           // [R1] [R4]
        end else if (opcode == OP_CONFIG_CLOCK) begin
          next_pump = 1'b1;                                                                            // [R5]
          next_arg  = {STATUS_OK, 28'h0000000};
        end else if (flash_call || opcode == OP_RESUME_NB) begin
          next_go      = 1'b1;
          next_op      = opcode;
          next_pending = opcode == OP_NB_WRITE_ROW || opcode == OP_NB_PROG_ROW;
          next_state   = RUN;
        end else
          next_arg = {STATUS_OK, 28'h0000000};
      end
      RUN: begin
        // flash engine runs; non-blocking calls release the caller here too
        // key on the running op, not on a stale pending flag from an earlier call
        if (flash_done || flash_op == OP_NB_WRITE_ROW || flash_op == OP_NB_PROG_ROW) begin
          next_arg   = {STATUS_OK, 28'h0000000};
          next_state = DONE;
          if (opcode == OP_RESUME_NB) next_pending = 1'b0;
        end
      end
      DONE: begin
        next_req[REQ_BIT]  = 1'b0;                                                                     // [R18]
        next_req[PRIV_BIT] = 1'b0;
        next_state = IDLE;
      end
      default: next_state = IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state              <= IDLE;
      call_argument_word <= 32'h00000000;
      call_request_word  <= 32'h00000000;
      pump_from_osc      <= 1'b0;
      flash_go           <= 1'b0;
      flash_op           <= 8'h00;
      pending            <= 1'b0;
      caller             <= 1'b0;
    end else begin
      state              <= next_state;
      call_argument_word <= next_arg;
      call_request_word  <= next_req;
      pump_from_osc      <= next_pump;
      flash_go           <= next_go;
      flash_op           <= next_op;
      pending            <= next_pending;
      caller             <= next_caller;
    end
  end

  ident_result_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R3]
    (state == CHECK && opcode == OP_IDENT && call_argument_word[15:0] == {SECOND_KEY_BASE, FIRST_KEY}
     && !(caller && protect_mode == MODE_KILL)) |=> call_argument_word[31:28] == STATUS_OK
     && call_request_word[11:0] == FAMILY_ID)
    else $error("identification result wrong");
  kill_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R7]
    (state == CHECK && opcode == OP_IDENT && caller && protect_mode == MODE_KILL)
    |=> call_argument_word[31:28] == 4'hf)
    else $error("identification not refused in kill");
  key_check_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R17]
    (state == CHECK && call_argument_word[7:0] != FIRST_KEY) |=> call_argument_word == 32'hf0000003)
    else $error("bad key not reported");
  done_clears_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R18]
    (state == DONE) |=> !call_request_word[REQ_BIT] && !call_request_word[PRIV_BIT])
    else $error("completion bits not cleared");
  no_flash_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R20]
    (state == CHECK && !allowed) |=> !flash_go)
    else $error("forbidden call reached flash");
  pump_check_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R6]
    (state == CHECK && flash_call && pump_from_osc && pump_freq_mhz != 8'(IMO_48MHZ_CODE))
    |=> !flash_go ##1 state == IDLE)
    else $error("flash run with bad pump clock");
  erase_debug_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R11]
    (flash_go && flash_op == OP_ERASE_ALL) |-> caller)
    else $error("erase all from processor");
  nb_cpu_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // [R14]
    (flash_go && (flash_op == OP_NB_WRITE_ROW || flash_op == OP_NB_PROG_ROW)) |-> !caller)
    else $error("non-blocking call from debug");
endmodule : flash_system_call_handler

// [tb/flash_engine_model.sv]
/*
  flash engine stand-in: each flash_go restarts a DELAY-cycle count that ends in one flash_done pulse.
  assumes the handler's clock and reset; the delay is a plain default.
*/
`timescale 1ns/1ps
module flash_engine_model #(
  parameter int DELAY = 4
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic flash_go,
  output logic      flash_done
);
  int cnt;
  // restart on a new go, so a repeated go gives one done pulse unless it lands while cnt is 1
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt        <= 0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt == 1);
      if (flash_go) cnt <= DELAY;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule : flash_engine_model

// [tb/test_flash_system_call_handler.sv]
/*
  self-checking bench for the system call handler.
  assumes the flash engine model on the far side; inputs move on falling edges.
*/
`timescale 1ns/1ps
module test_flash_system_call_handler;
  import syscall_pkg::*;
  localparam logic [11:0] FAM = 12'h3c5;   // arbitrary value
  localparam logic [15:0] SID = 16'h5a7e;  // arbitrary value
  localparam logic [7:0]  REV = 8'h23;     // arbitrary value
  localparam logic [31:0] NO_ACC = STATUS_FAIL_BASE | {24'h0, ERR_NO_ACCESS};
  localparam logic [0:20][11:0] ACC = {
    {OP_IDENT, 3'b100, 1'b1}, {OP_IDENT, 1'b1, MODE_KILL, 1'b0}, {OP_IDENT, 1'b0, MODE_KILL, 1'b1},
    {OP_LOAD_BYTES, 3'b100, 1'b1}, {OP_LOAD_BYTES, 3'b101, 1'b0}, {OP_LOAD_BYTES, 3'b001, 1'b1},
    {OP_WRITE_ROW, 3'b100, 1'b1}, {OP_WRITE_ROW, 3'b101, 1'b0},
    {OP_PROGRAM_ROW, 3'b101, 1'b0}, {OP_PROGRAM_ROW, 3'b000, 1'b1},
    {OP_ERASE_ALL, 3'b100, 1'b1}, {OP_ERASE_ALL, 3'b000, 1'b0},
    {OP_CHECKSUM, 3'b101, 1'b1}, {OP_CHECKSUM, 3'b110, 1'b0}, {OP_CHECKSUM, 3'b000, 1'b1},
    {OP_WRITE_PROTECT, 3'b101, 1'b1}, {OP_WRITE_PROTECT, 3'b000, 1'b0},
    {OP_NB_PROG_ROW, 3'b100, 1'b0}, {OP_RESUME_NB, 3'b100, 1'b0}, {OP_NB_WRITE_ROW, 3'b000, 1'b1},
    {OP_RESUME_NB, 3'b000, 1'b1}};
  logic        sys_clk = 0, rst_b = 0, arg_wr = 0, req_wr = 0, dbg = 0;
  logic [31:0] wr_data = 0, arg_w, req_w;
  logic [1:0]  mode = 0;
  logic [7:0]  pump = 8'd48, f_op;
  logic        pump_osc, go, flash_done, priv_seen;
  int          fail_count = 0, n_checks = 0, cycles = 0, gos;

  flash_system_call_handler #(.FAMILY_ID(FAM), .SILICON_ID(SID), .REVISION(REV)) i_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .arg_wr(arg_wr), .req_wr(req_wr), .wr_data(wr_data),
    .caller_is_debug(dbg), .protect_mode(mode), .pump_freq_mhz(pump), .flash_done(flash_done),
    .call_argument_word(arg_w), .call_request_word(req_w), .pump_from_osc(pump_osc),
    .flash_go(go), .flash_op(f_op));
  flash_engine_model i_engine (.sys_clk(sys_clk), .rst_b(rst_b), .flash_go(go), .flash_done(flash_done));

  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize

  // arg word first, then opcode with the request bit; wait for both flags clear
  task automatic call(input logic [31:0] a, input logic [7:0] op, input logic d);
    gos = 0;
    priv_seen = 0;
    @(negedge sys_clk);
    arg_wr = 1;
    wr_data = a;
    @(negedge sys_clk);
    arg_wr = 0;
    req_wr = 1;
    dbg = d;
    wr_data = {24'h800000, op};
    @(negedge sys_clk);
    req_wr = 0;
    for (int i = 0; i < 200; i++) begin
      @(negedge sys_clk);
      gos += go;
      priv_seen |= req_w[PRIV_BIT];
      if (req_w[REQ_BIT] === 1'b0 && req_w[PRIV_BIT] === 1'b0) break;
    end
    check({30'h0, req_w[31:30]}, 32'h0);
  endtask : call

  task automatic op_call(input logic [7:0] op, input logic d);
    call({16'h0, SECOND_KEY_BASE + op, FIRST_KEY}, op, d);
  endtask : op_call

  task automatic t_ident();
    mode = MODE_PROTECTED;
    op_call(OP_IDENT, 1'b1);
    check(arg_w, {STATUS_OK, 4'h0, REV, SID});
    check({16'h0, req_w[15:0]}, {16'h0, 2'b0, MODE_PROTECTED, FAM});
    check({31'h0, priv_seen}, 32'h1);
  endtask : t_ident

  task automatic t_keys();
    mode = MODE_OPEN;
    call({16'h0, 8'hd4, FIRST_KEY}, OP_IDENT, 1'b0);
    check(arg_w, STATUS_FAIL_BASE | {24'h0, ERR_BAD_KEY});
    call({16'h0, SECOND_KEY_BASE, 8'hb7}, OP_IDENT, 1'b0);
    check(arg_w, STATUS_FAIL_BASE | {24'h0, ERR_BAD_KEY});
    op_call(8'h33, 1'b0);
    check(arg_w, STATUS_FAIL_BASE | {24'h0, ERR_BAD_OPCODE});
  endtask : t_keys

  // off-frequency pump must stop the write before the engine is started
  task automatic t_pump();
    pump = 8'd47;
    op_call(OP_CONFIG_CLOCK, 1'b0);
    check({31'h0, pump_osc}, 32'h1);
    op_call(OP_WRITE_ROW, 1'b0);
    check(arg_w, STATUS_FAIL_BASE | {24'h0, ERR_PUMP_CLOCK});
    check(32'(gos), 32'h0);
    pump = 8'd48;
    op_call(OP_WRITE_ROW, 1'b0);
    check(32'(gos), 32'h1);
    check({24'h0, f_op}, {24'h0, OP_WRITE_ROW});
    check({28'h0, arg_w[31:28]}, {28'h0, STATUS_OK});
    op_call(OP_RESUME_NB, 1'b0);
    check(arg_w, STATUS_FAIL_BASE | {24'h0, ERR_NO_PENDING});
  endtask : t_pump

  // last two entries: a processor non-blocking write, then its resume
  task automatic t_access();
    logic [7:0] op;
    logic       d, ok;
    logic [1:0] m;
    for (int i = 0; i < 21; i++) begin
      {op, d, m, ok} = ACC[i];
      mode = m;
      op_call(op, d);
      if (ok) check({28'h0, arg_w[31:28]}, {28'h0, STATUS_OK});
      else check(arg_w, NO_ACC);
      if (!ok) check(32'(gos), 32'h0);
    end
  endtask : t_access

  initial begin
    repeat (5) @(negedge sys_clk);
    rst_b = 1;
    check(arg_w, 32'h0);
    check(req_w, 32'h0);
    t_ident();
    t_keys();
    t_pump();
    t_access();
    summarize();
  end
endmodule : test_flash_system_call_handler
